// ==== overlay_cfg.svh ====
// Constants for the text overlay row decoder: offsets, field positions, reset values.
// Assumes inclusion by the decoder module only.
`ifndef OVERLAY_CFG_SVH
`define OVERLAY_CFG_SVH
// Byte offsets relative to the row base, added to z times the cell size (cell z starts at 1)
`define SER_CELL_OFS   8'h05
`define BAS_CODE_OFS   8'h04
`define BAS_PAL_OFS    8'h05
`define EXT_CODE_OFS   8'h03
`define EXT_PAL_OFS    8'h04
`define EXT_SHAPE_OFS  8'h05
// Serial byte fields
`define SER_ATTR_BIT   7
`define SER_BACK_BIT   6
`define SER_BLINK_BIT  5
`define SER_SLANT_BIT  4
// Shape byte fields
`define SHP_CODE_HIGH  7
`define SHP_DBL_H      6
`define SHP_DBL_W      5
`define SHP_FORE_EXT   4
`define SHP_BACK_EXT   3
`define SHP_BLINK      2
`define SHP_SHADOW     1
`define SHP_HALO       0
// Palette byte base addresses of entry zero (palette swap clear)
`define FORE_PAL_BASE  8'h10
`define BACK_PAL_BASE  8'h30
// Register port offsets
`define REG_CTRL       4'h0
`define REG_ROW        4'h1
`define REG_COUNT      4'h2
`define REG_STATUS     4'h3
`define REG_GLYPH_LO   4'h4
`define REG_GLYPH_HI   4'h5
`define REG_PTRS       4'h6
`define REG_FLAGS      4'h7
`define REG_BASE       4'h8
`define CTRL_RESET     8'h00
`define ROW_RESET      8'h00
`define COUNT_RESET    6'h01
`define BASE_RESET     9'h000
`endif

// ==== overlay_pkg.sv ====
// Types shared by the text overlay row decoder.
// Assumes the constants header is compiled alongside.
package overlay_pkg;
   // Cell layout modes of a row
   typedef enum logic [1:0] {MODE_SERIAL, MODE_BASIC, MODE_EXTENDED, MODE_UNUSED} cell_mode_e;
   // Decoder sequencing
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_EMIT} walk_state_e;
   typedef logic [8:0] ram_addr_t;
endpackage

// ==== text_overlay_row_decoder.sv ====
// Row decoder: walks one row buffer of display RAM and decodes each cell into
// glyph address, palette pointers and per-glyph drawing controls.
// Assumes a synchronous display RAM with one cycle read latency and a host that
// has filled the row buffer before starting a walk.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`include "overlay_cfg.svh"

module text_overlay_row_decoder
   import overlay_pkg::*;
(
   input  wire logic       clk_sys_in,      // 250 MHz system clock
   input  wire logic       nrst_in,         // Synchronous reset, active low
   input  wire logic [3:0] reg_addr_in,     // Register address
   input  wire logic [7:0] reg_wdata_in,    // Register write data
   input  wire logic       reg_wr_in,       // Write strobe
   input  wire logic       reg_rd_in,       // Read strobe
   output logic      [7:0] reg_rdata_out,   // Read data, cycle after strobe
   output logic      [8:0] ram_addr_out,    // Display RAM byte address
   output logic            ram_rd_out,      // Display RAM read request
   input  wire logic [7:0] ram_rdata_in,    // Display RAM data, one cycle later
   output logic            cell_valid_out,  // One-cycle pulse per decoded cell
   output logic     [10:0] glyph_addr_out,  // Font memory glyph index
   output logic      [4:0] fore_ptr_out,    // Bank bit and foreground pointer
   output logic      [4:0] back_ptr_out,    // Bank bit and background pointer
   output logic      [7:0] fore_pal_addr_out, // Palette byte address, foreground
   output logic      [7:0] back_pal_addr_out, // Palette byte address, background
   output logic            blank_out,       // Draw cell as background space
   output logic            slant_out,       // Italic drawing
   output logic            shadow_out,      // Shadow on right and bottom
   output logic            halo_out,        // Fringe around foreground
   output logic            dbl_height_out,  // Double height
   output logic            dbl_width_out,   // Double width
   output logic            upper_half_out,  // Upper half of a tall glyph
   output logic            skip_out,        // Cell covered by a wide neighbour
   output logic            busy_out         // Row walk in progress
);

   // Control: [1:0] mode, [2] palette swap, [3] start (self clearing)
   logic [7:0]  ctrl_q;
   // Row attributes: [7] matrix, [6] upper half, [4] vert, [3] horiz, [2] blink, [0] halo
   logic [7:0]  row_q;
   logic [5:0]  count_q;           // Glyph count of the row
   ram_addr_t   base_q;            // Row base address, always even
   walk_state_e state_q;           // Walk sequencer
   logic [5:0]  cell_q;            // Current cell z, from 1
   logic [1:0]  byte_q;            // Byte index within a cell
   logic [7:0]  code_q;            // Captured code byte
   logic [7:0]  pal_q;             // Captured palette byte
   logic        done_q;            // Sticky: last walk finished
   logic        blink_follow_q;    // Serial: later glyphs blink
   logic        slant_select_q;    // Serial: later glyphs slant
   logic [3:0]  fore_ser_q;        // Serial fore pointer
   logic [3:0]  back_ser_q;        // Serial back pointer
   logic        wide_pend_q;       // Previous glyph was double width

   cell_mode_e  mode;
   logic        palette_swap_sel;
   logic        blink_row_on;
   logic        edge_halo_row;
   logic        font_matrix_select;
   logic [1:0]  bytes_per_cell;
   logic        last_byte;
   logic        start;

   // Mode code 3 is not defined; it decodes as serial but never loads the serial running attributes
   assign mode               = cell_mode_e'(ctrl_q[1:0]);
   assign palette_swap_sel   = ctrl_q[2];
   // Start is taken straight from the write strobe, never stored
   assign start              = reg_wr_in && (reg_addr_in == `REG_CTRL) && reg_wdata_in[3];
   assign blink_row_on       = row_q[2];
   assign edge_halo_row      = row_q[0];
   assign font_matrix_select = row_q[7];
   assign bytes_per_cell     = (mode == MODE_EXTENDED) ? 2'd3 :
                               (mode == MODE_BASIC) ? 2'd2 : 2'd1;
   assign last_byte          = (byte_q == bytes_per_cell - 2'd1);

   // Byte address of cell z, byte b; one helper serves all three layouts
   function automatic ram_addr_t cell_byte_addr(input ram_addr_t base, input cell_mode_e m,
                                                input logic [5:0] z, input logic [1:0] b);
      logic [8:0] zz;
      zz = {3'b000, z};
      case (m)
         MODE_BASIC:    cell_byte_addr = base + {1'b0, `BAS_CODE_OFS} + 9'(zz * 2) + 9'(b);
         MODE_EXTENDED: cell_byte_addr = base + {1'b0, `EXT_CODE_OFS} + 9'(zz * 3) + 9'(b);
         default:       cell_byte_addr = base + {1'b0, `SER_CELL_OFS} + zz;
      endcase
   endfunction

   // Palette byte address from bank-less pointer; entries are two bytes apart
   // Bank bit is not part of this address; it travels on the pointer ports
   function automatic logic [7:0] pal_addr(input logic [7:0] base, input logic [3:0] ptr);
      pal_addr = base + {3'b000, ptr, 1'b0};
   endfunction

   // Register writes; reserved control and count bits dropped, row bits all stored
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         ctrl_q  <= `CTRL_RESET;
         row_q   <= `ROW_RESET;
         count_q <= `COUNT_RESET;
         base_q  <= `BASE_RESET;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            `REG_CTRL:  ctrl_q  <= {5'b00000, reg_wdata_in[2:0]};
            `REG_ROW:   row_q   <= reg_wdata_in;
            `REG_COUNT: count_q <= reg_wdata_in[5:0];
            // Low bit forced to zero: row buffers sit at even addresses
            `REG_BASE:  base_q  <= {reg_wdata_in, 1'b0};
            default:    ctrl_q  <= ctrl_q;
         endcase
      end
   end

   // Register reads, answered one cycle later; unmapped reads give zero
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
      begin
         case (reg_addr_in)
            `REG_CTRL:     reg_rdata_out <= ctrl_q;
            `REG_ROW:      reg_rdata_out <= row_q;
            `REG_COUNT:    reg_rdata_out <= {2'b00, count_q};
            `REG_STATUS:   reg_rdata_out <= {6'h00, done_q, busy_out};
            `REG_GLYPH_LO: reg_rdata_out <= glyph_addr_out[7:0];
            `REG_GLYPH_HI: reg_rdata_out <= {5'h00, glyph_addr_out[10:8]};
            `REG_PTRS:     reg_rdata_out <= {fore_ptr_out[3:0], back_ptr_out[3:0]};
            `REG_FLAGS:    reg_rdata_out <= {1'b0, skip_out, dbl_width_out, dbl_height_out,
                                             halo_out, shadow_out, slant_out, blank_out};
            `REG_BASE:     reg_rdata_out <= base_q[8:1];
            default:       reg_rdata_out <= 8'h00;
         endcase
      end
      else
         reg_rdata_out <= 8'h00;
   end

   // Walk sequencer: fetch each byte, wait for RAM, emit on a cell's last byte
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         state_q <= ST_IDLE;
         cell_q  <= 6'h01;
         byte_q  <= 2'd0;
         done_q  <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  state_q <= ST_FETCH;
                  cell_q  <= 6'h01;
                  byte_q  <= 2'd0;
                  done_q  <= 1'b0;
               end
            end
            ST_FETCH:
               // RAM answers one cycle after the request
               state_q <= ST_WAIT;
            ST_WAIT:
            begin
               if (last_byte)
                  state_q <= ST_EMIT;
               else
               begin
                  byte_q  <= byte_q + 2'd1;
                  state_q <= ST_FETCH;
               end
            end
            ST_EMIT:
            begin
               byte_q <= 2'd0;
               // Finish after the counted cell; a count of zero walks one cell
               // Next cell starts fetching straight after emit, no gap
               if (cell_q >= count_q)
               begin
                  state_q <= ST_IDLE;
                  done_q  <= 1'b1;
               end
               else
               begin
                  cell_q  <= cell_q + 6'h01;
                  state_q <= ST_FETCH;
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // RAM request driven combinationally from the sequencer
   // Address follows the cell and byte counters with no register stage
   always_comb
   begin
      ram_rd_out   = (state_q == ST_FETCH);
      ram_addr_out = cell_byte_addr(base_q, mode, cell_q, byte_q);
      busy_out     = (state_q != ST_IDLE);
   end

   // Shape byte is not stored; the emit cycle reads it off the RAM lines
   // Capture code and palette bytes as they return
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         code_q <= 8'h00;
         pal_q  <= 8'h00;
      end
      else if (state_q == ST_WAIT)
      begin
         if (byte_q == 2'd0)
            code_q <= ram_rdata_in;
         else if (byte_q == 2'd1)
            pal_q <= ram_rdata_in;
      end
   end

   // Serial running attributes; cleared at the start of each row
   // A start while busy also clears these, so hosts should wait for idle
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || start)
      begin
         blink_follow_q <= 1'b0;
         slant_select_q <= 1'b0;
         fore_ser_q     <= 4'h0;
         back_ser_q     <= 4'h0;
      end
      else if (state_q == ST_WAIT && mode == MODE_SERIAL && ram_rdata_in[`SER_ATTR_BIT])
      begin
         if (ram_rdata_in[`SER_BACK_BIT])
            back_ser_q <= ram_rdata_in[3:0];                     // Bits 5:4 unused
         else
         begin
            blink_follow_q <= ram_rdata_in[`SER_BLINK_BIT];
            slant_select_q <= ram_rdata_in[`SER_SLANT_BIT];
            fore_ser_q     <= ram_rdata_in[3:0];
         end
      end
   end

   // Double width only from an 18x26 extended shape byte
   // Shared by the carry flag and the decoded output so both agree
   function automatic logic dbl_width_d();
      dbl_width_d = (mode == MODE_EXTENDED) && font_matrix_select
                    && ram_rdata_in[`SHP_DBL_W];
   endfunction

   // Double-width carry: the following cell is decoded but marked as skipped
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || start)
         wide_pend_q <= 1'b0;
      else if (state_q == ST_EMIT)
         wide_pend_q <= !wide_pend_q && dbl_width_d();
   end

   // Decode outputs, registered on the emit cycle
   // Levels hold between pulses so software can read them back
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         cell_valid_out    <= 1'b0;
         glyph_addr_out    <= 11'h000;
         fore_ptr_out      <= 5'h00;
         back_ptr_out      <= 5'h00;
         fore_pal_addr_out <= `FORE_PAL_BASE;
         back_pal_addr_out <= `BACK_PAL_BASE;
         blank_out         <= 1'b0;
         slant_out         <= 1'b0;
         shadow_out        <= 1'b0;
         halo_out          <= 1'b0;
         dbl_height_out    <= 1'b0;
         dbl_width_out     <= 1'b0;
         upper_half_out    <= 1'b0;
         skip_out          <= 1'b0;
      end
      else
      begin
         cell_valid_out <= (state_q == ST_EMIT);
         if (state_q == ST_EMIT)
         begin
            skip_out       <= wide_pend_q;
            upper_half_out <= row_q[6];
            case (mode)
               MODE_BASIC:
               begin
                  glyph_addr_out    <= {3'b000, code_q};
                  fore_ptr_out      <= {palette_swap_sel, pal_q[7:4]};
                  back_ptr_out      <= {palette_swap_sel, pal_q[3:0]};
                  fore_pal_addr_out <= pal_addr(`FORE_PAL_BASE, pal_q[7:4]);
                  back_pal_addr_out <= pal_addr(`BACK_PAL_BASE, pal_q[3:0]);
                  // Basic mode has no per-glyph blink or size controls
                  blank_out      <= 1'b0;
                  slant_out      <= 1'b0;
                  shadow_out     <= 1'b0;
                  halo_out       <= 1'b0;
                  dbl_height_out <= 1'b0;
                  dbl_width_out  <= 1'b0;
               end
               MODE_EXTENDED:
               begin
                  // Shape byte is still on the RAM data lines this cycle
                  if (font_matrix_select)
                     glyph_addr_out <= {2'b00, ram_rdata_in[`SHP_CODE_HIGH], code_q};
                  else
                     glyph_addr_out <= {ram_rdata_in[7:5], code_q};
                  fore_ptr_out <= {palette_swap_sel ^ ram_rdata_in[`SHP_FORE_EXT],
                                   pal_q[7:4]};
                  back_ptr_out <= {palette_swap_sel ^ ram_rdata_in[`SHP_BACK_EXT],
                                   pal_q[3:0]};
                  fore_pal_addr_out <= pal_addr(`FORE_PAL_BASE, pal_q[7:4]);
                  back_pal_addr_out <= pal_addr(`BACK_PAL_BASE, pal_q[3:0]);
                  blank_out  <= ram_rdata_in[`SHP_BLINK] && blink_row_on;
                  slant_out  <= 1'b0;
                  shadow_out <= ram_rdata_in[`SHP_SHADOW];
                  halo_out   <= ram_rdata_in[`SHP_HALO] && edge_halo_row;
                  dbl_height_out <= font_matrix_select && ram_rdata_in[`SHP_DBL_H];
                  dbl_width_out  <= dbl_width_d();
               end
               default:
               begin
                  // Serial: attribute cells draw as background spaces
                  glyph_addr_out    <= {4'h0, code_q[6:0]};
                  fore_ptr_out      <= {palette_swap_sel, fore_ser_q};
                  back_ptr_out      <= {palette_swap_sel, back_ser_q};
                  fore_pal_addr_out <= pal_addr(`FORE_PAL_BASE, fore_ser_q);
                  back_pal_addr_out <= pal_addr(`BACK_PAL_BASE, back_ser_q);
                  blank_out  <= code_q[`SER_ATTR_BIT] || (blink_follow_q && blink_row_on);
                  slant_out  <= slant_select_q;
                  shadow_out <= 1'b0;
                  halo_out   <= edge_halo_row;
                  dbl_height_out <= 1'b0;
                  dbl_width_out  <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// ==== display_ram_model.sv ====
// Display RAM model standing on the far side of the row decoder.
// Assumes the bench loads row buffers straight into mem before a walk.
`timescale 1ns/1ps
module display_ram_model (
   input  wire logic       clk_sys_in,    // System clock
   input  wire logic [8:0] ram_addr_in,   // Byte address from the decoder
   input  wire logic       ram_rd_in,     // Read request
   output logic      [7:0] ram_rdata_out  // Read data, one cycle later
);
   logic [7:0] mem [0:511];  // Row buffers, filled by the host side

   // Synchronous read; data holds until the next read, since the
   // decoder samples the shape byte only in its emit cycle, a cycle after it returns
   always_ff @(posedge clk_sys_in)
   begin
      if (ram_rd_in)
         ram_rdata_out <= mem[ram_addr_in];
   end
endmodule

// ==== overlay_decoder_asserts.sv ====
// Port-level assertions for the text overlay row decoder.
// Assumes it is bound to the decoder top and sees its ports only.
`timescale 1ns/1ps
module overlay_decoder_asserts (
   input  wire logic       clk_sys_in,
   input  wire logic       nrst_in,
   input  wire logic [3:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_rdata_out,
   input  wire logic [8:0] ram_addr_out,
   input  wire logic       ram_rd_out,
   input  wire logic       cell_valid_out,
   input  wire logic [4:0] fore_ptr_out,
   input  wire logic [4:0] back_ptr_out,
   input  wire logic [7:0] fore_pal_addr_out,
   input  wire logic [7:0] back_pal_addr_out,
   input  wire logic       skip_out,
   input  wire logic       dbl_height_out,
   input  wire logic       busy_out
);
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   // Read data only in the cycle after a read strobe
   rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data without a read strobe");
   fore_pal_a: assert property (
      fore_pal_addr_out == 8'h10 + {3'b000, fore_ptr_out[3:0], 1'b0})
      else $error("foreground palette address wrong");
   back_pal_a: assert property (
      back_pal_addr_out == 8'h30 + {3'b000, back_ptr_out[3:0], 1'b0})
      else $error("background palette address wrong");
   // Bytes of one cell sit at consecutive addresses
   addr_step_a: assert property (
      ram_rd_out ##2 ram_rd_out |-> ram_addr_out == $past(ram_addr_out, 2) + 9'd1)
      else $error("cell bytes not fetched in order");
   emit_valid_a: assert property (ram_rd_out ##2 !ram_rd_out |=> cell_valid_out)
      else $error("cell not emitted after its last byte");
   walk_bound_a: assert property ($rose(busy_out) |-> ##[1:460] !busy_out)
      else $error("row walk does not end");
   start_walk_a: assert property (
      reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[3] && !busy_out
      |=> busy_out && ram_rd_out)
      else $error("start did not begin a fetch");
   idle_quiet_a: assert property (!busy_out |-> !ram_rd_out)
      else $error("RAM read while idle");
   valid_pulse_a: assert property (cell_valid_out |=> !cell_valid_out)
      else $error("cell valid longer than one cycle");
   fetch_wait_a: assert property (ram_rd_out |=> !ram_rd_out)
      else $error("fetch not followed by a wait");

   // Main scenarios reached
   cover property (cell_valid_out && skip_out);
   cover property (cell_valid_out && dbl_height_out);
   cover property ($fell(busy_out));
endmodule

// ==== text_overlay_row_decoder_test.sv ====
// Self-checking bench for the text overlay row decoder.
// Assumes the RAM model answers every fetch; rows start at base 20h.
`timescale 1ns/1ps
module text_overlay_row_decoder_test;
   import overlay_pkg::*;
   // Table row: control, row attribute, count, bytes, expected outputs
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  row;
      logic [5:0]  n;
      logic [47:0] b;
      logic [10:0] glyph;
      logic [4:0]  fp;
      logic [4:0]  bp;
      logic [7:0]  fl;
   } case_s;
   logic        clk_sys_in   = 1'b0;
   logic        nrst_in      = 1'b0;
   logic [3:0]  reg_addr_in  = 4'h0;
   logic [7:0]  reg_wdata_in = 8'h00;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic [7:0]  reg_rdata_out, ram_rdata_in, fore_pal_addr_out, back_pal_addr_out, rv;
   logic [8:0]  ram_addr_out;
   logic [10:0] glyph_addr_out;
   logic [4:0]  fore_ptr_out, back_ptr_out;
   logic        ram_rd_out, cell_valid_out, blank_out, slant_out, shadow_out, halo_out;
   logic        dbl_height_out, dbl_width_out, upper_half_out, skip_out, busy_out;
   int          err_total    = 0;
   int          comparisons  = 0;
   case_s       rows [8];
   wire  [7:0]  flags = {upper_half_out, skip_out, dbl_width_out, dbl_height_out,
                         halo_out, shadow_out, slant_out, blank_out};

   text_overlay_row_decoder u_text_overlay_row_decoder (.*);
   display_ram_model u_display_ram_model (.clk_sys_in(clk_sys_in),
      .ram_addr_in(ram_addr_out), .ram_rd_in(ram_rd_out), .ram_rdata_out(ram_rdata_in));

   // 250 MHz clock
   always #2 clk_sys_in = ~clk_sys_in;

   // Value compare; case inequality so unknowns fail
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Closing report and verdict
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b0;
   endtask

   // Register read; data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_sys_in);
      d = reg_rdata_out;
   endtask

   // Load cell bytes from 26h, start a walk, wait for n cells and idle
   task automatic walk(input logic [7:0] ctrl, input logic [7:0] row,
                       input logic [5:0] n, input logic [47:0] b);
      int k;
      int cells;
      for (k = 0; k < 6; k++)
         u_display_ram_model.mem[9'h026 + k] = b[47 - 8 * k -: 8];
      wr(4'h1, row);
      wr(4'h2, {2'b00, n});
      wr(4'h0, ctrl | 8'h08); // Start only once the row is set up
      cells = 0;
      k = 0;
      // Bounded wait on the last cell, then unbounded wait on idle
      while ((cells < n || busy_out !== 1'b0) && k < 600)
      begin
         @(negedge clk_sys_in);
         if (cell_valid_out === 1'b1 && cells < n)
            cells++;
         if (cells < n)
            k++;
      end
      if (k >= 600)
      begin
         err_total++;
         $display("BAD %0t walk did not finish", $time);
      end
   endtask

   // Hang guard, far above the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      err_total++;
      end_sim;
   end

   initial
   begin
      // Serial fore attr then code; flash, slant, row blink on or off
      rows[0] = '{8'h00, 8'h04, 6'd2, 48'hB541_0000_0000, 11'h041, 5'h05, 5'h00, 8'h03};
      rows[1] = '{8'h00, 8'h00, 6'd2, 48'hB541_0000_0000, 11'h041, 5'h05, 5'h00, 8'h02};
      // Serial back attr with reserved bits set, swap on, row halo
      rows[2] = '{8'h04, 8'h01, 6'd2, 48'hFA7F_0000_0000, 11'h07F, 5'h10, 5'h1A, 8'h08};
      // Second fore attr ends slant and flash
      rows[3] = '{8'h00, 8'h04, 6'd3, 48'hB08C_2200_0000, 11'h022, 5'h0C, 5'h00, 8'h00};
      // Basic: full code, palette nibbles, no blink in this mode
      rows[4] = '{8'h05, 8'h04, 6'd1, 48'hC39E_0000_0000, 11'h0C3, 5'h19, 5'h1E, 8'h00};
      // Extended 9x13: code bits from shape, blink, shadow, halo
      rows[5] = '{8'h02, 8'h05, 6'd1, 48'h5A21_D700_0000, 11'h65A, 5'h12, 5'h01, 8'h0D};
      // Extended 18x26: tall upper half, swap, halo gated off by row
      rows[6] = '{8'h06, 8'hC4, 6'd1, 48'hE13C_CB00_0000, 11'h1E1, 5'h13, 5'h0C, 8'h94};
      // Extended 18x26: wide glyph in the final cell still flags double width
      rows[7] = '{8'h02, 8'h80, 6'd1, 48'h4100_2000_0000, 11'h041, 5'h00, 5'h00, 8'h20};
      repeat (10) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(negedge clk_sys_in);
      // Reset values at the ports
      chk(fore_pal_addr_out, 11'h010);
      chk(back_pal_addr_out, 11'h030);
      chk(ram_addr_out, 11'h006); // Serial cell one sits at base plus six
      chk({busy_out, cell_valid_out}, 11'h000);
      chk(glyph_addr_out, 11'h000);
      rd(4'h2, rv);
      chk(rv, 11'h001);
      rd(4'hC, rv);
      chk(rv, 11'h000);
      wr(4'h8, 8'h10);
      // Table of ordinary cells, last cell of each walk checked
      foreach (rows[i])
      begin
         walk(rows[i].ctrl, rows[i].row, rows[i].n, rows[i].b);
         chk(glyph_addr_out, rows[i].glyph);
         chk(fore_ptr_out, rows[i].fp);
         chk(back_ptr_out, rows[i].bp);
         chk(fore_pal_addr_out, 11'(11'h010 + 2 * rows[i].fp[3:0]));
         chk(back_pal_addr_out, 11'(11'h030 + 2 * rows[i].bp[3:0]));
         chk(flags, rows[i].fl);
      end
      // Wide glyph covers the next cell, which is read but skipped
      walk(8'h02, 8'h80, 6'd2, 48'h4100_2042_0000);
      chk(skip_out, 11'h001);
      chk(glyph_addr_out, 11'h042);
      rd(4'h7, rv);
      chk(rv, 11'h040);
      // Status shows done and idle; base reads back as stored
      rd(4'h3, rv);
      chk(rv, 11'h002);
      rd(4'h8, rv);
      chk(rv, 11'h010);
      // Reset in mid-walk stops it at once
      u_display_ram_model.mem[9'h029] = 8'h00;
      wr(4'h2, 8'h14);
      wr(4'h0, 8'h0A);
      repeat (10) @(posedge clk_sys_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(negedge clk_sys_in);
      chk({busy_out, cell_valid_out, ram_rd_out}, 11'h000);
      chk(back_pal_addr_out, 11'h030);
      end_sim;
   end
endmodule

bind text_overlay_row_decoder overlay_decoder_asserts u_overlay_decoder_asserts (
   .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out),
   .cell_valid_out(cell_valid_out), .fore_ptr_out(fore_ptr_out),
   .back_ptr_out(back_ptr_out), .fore_pal_addr_out(fore_pal_addr_out),
   .back_pal_addr_out(back_pal_addr_out), .skip_out(skip_out),
   .dbl_height_out(dbl_height_out), .busy_out(busy_out));
